// *** logic/ietu_top.sv ***
`timescale 1ns/1ns
// Overview of operation
// - each node routes to vector or transfer
// - standard service branches to node vector
// - transfer steals exactly one cpu cycle
// - move byte/word, bump source/destination pointers
// - count decrements per transfer, not continuous
// - count reaching zero raises standard interrupt
// - eight channels with own pointers, counter
// - response latency seven or eleven clocks
// - 112 nodes: flag, enable, priority each
// - select registers pick shared node sources
// - four router inputs, rise/fall/both detection
// - four gating units with pattern filter
// - hardware trap branches to its vector
// - each trap sets its own flag bit
// - trap preempts unless same or more urgent trap runs
// - interrupts, transfers wait while trap runs
// - three request pins make two system traps
// - software trap invokes service for number
// - writing request flag raises node request
// - enabled guard turns violations into traps
module ietu_top (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic              hreadyout,
  output logic              hresp,
  output logic [31:0]       hrdata,
  input  wire logic [111:0] srcReq,
  input  wire logic [7:0]   altSrc,
  input  wire logic [3:0]   rtrPin,
  input  wire logic [2:0]   srvPin,
  input  wire logic [4:0]   hwTrap,
  input  wire logic         accessViolation,
  input  wire logic         swTrapValid,
  input  wire logic [7:0]   swTrapNum,
  output logic              svcValid,
  output logic [7:0]        svcVector,
  output logic              svcIsTrap,
  input  wire logic         svcAck,
  input  wire logic         trapDone,
  output logic              xferValid,
  output logic              xferWord,
  output logic [23:0]       xferSrc,
  output logic [23:0]       xferDst,
  output logic              cpuStall
);
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_VECTOR, ST_MOVE} ietu_state_t;

  ietu_state_t          state_q;
  logic [9:0]           nodeCtrl_q [ietu_pkg::NODES];
  logic [3:0]           chCtrl_q   [ietu_pkg::CHANS];
  logic [23:0]          chSrc_q    [ietu_pkg::CHANS];
  logic [23:0]          chDst_q    [ietu_pkg::CHANS];
  logic [7:0]           chCnt_q    [ietu_pkg::CHANS];
  logic [7:0]           trapFlags_q;
  logic [7:0]           trapPend_q;
  logic [3:0]           trapLevel_q;
  logic [3:0]           global_q;
  logic [7:0]           srcSel_q;
  logic [19:0]          rtrCfg_q;
  logic [15:0]          rtrMap_q;
  logic                 swPend_q;
  logic [7:0]           swNum_q;
  logic [3:0]           cnt_q;
  logic [7:0]           vec_q;
  logic                 isTrap_q;
  logic                 isNode_q;
  logic [6:0]           gIdx_q;
  logic                 wrPend_q;
  logic [11:0]          wrAddr_q;
  logic [31:0]          hrdata_q;
  logic                 addrValid;
  logic [31:0]          rdData;
  logic [111:0]         nodeSrc;
  logic [6:0]           best;
  logic                 found;
  logic [3:0]           bestPri;
  logic [2:0]           trapIdx;
  logic                 trapPick;
  logic [7:0]           trapEvt;
  logic [2:0]           gCh;
  logic [3:0]           rtrLvl;
  logic [3:0]           rtrEvt;
  logic [3:0]           gateReq;
  logic [2:0]           srvEvt;
  logic                 moveNow;
  logic                 hitZero;
  logic                 clrNode;

  // true when a word write lands on this offset in the data phase
  function automatic logic wrHit(input logic [11:0] off);
    wrHit = wrPend_q && (wrAddr_q == off);
  endfunction

  // bus slave: zero wait states, always OKAY, read data registered at address phase
  assign addrValid = hsel && htrans[1] && hready && (haddr[31:12] == 20'h0_0000);
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 12'h000;
      hrdata_q <= 32'h0000_0000;
    end
    else
    begin
      wrPend_q <= addrValid && hwrite;
      wrAddr_q <= {haddr[11:2], 2'b00};
      if (addrValid && !hwrite)
        hrdata_q <= rdData;
    end
  end
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  // read multiplexer, unmapped words read as zero
  always_comb
  begin
    rdData = 32'h0000_0000;
    if (haddr[11:0] <= ietu_pkg::A_NODE_LAST)
      rdData = {22'h00_0000, nodeCtrl_q[haddr[8:2]]};
    else if (haddr[11:7] == ietu_pkg::A_CHAN_BASE[11:7])
    begin
      case (haddr[3:2])
        ietu_pkg::CR_CTRL: rdData = {28'h000_0000, chCtrl_q[haddr[6:4]]};
        ietu_pkg::CR_SRC:  rdData = {8'h00, chSrc_q[haddr[6:4]]};
        ietu_pkg::CR_DST:  rdData = {8'h00, chDst_q[haddr[6:4]]};
        default:           rdData = {24'h00_0000, chCnt_q[haddr[6:4]]};
      endcase
    end
    else
    begin
      case ({haddr[11:2], 2'b00})
        ietu_pkg::A_TRAP_FLAGS: rdData = {24'h00_0000, trapFlags_q};
        ietu_pkg::A_GLOBAL:     rdData = {28'h000_0000, global_q};
        ietu_pkg::A_SRC_SEL:    rdData = {24'h00_0000, srcSel_q};
        ietu_pkg::A_RTR_CFG:    rdData = {12'h000, rtrCfg_q};
        ietu_pkg::A_RTR_MAP:    rdData = {16'h0000, rtrMap_q};
        ietu_pkg::A_STATUS:     rdData = {18'h0_0000, (state_q != ST_IDLE), trapLevel_q, isTrap_q,
                                          vec_q};
        default:                rdData = 32'h0000_0000;
      endcase
    end
  end

  // configuration registers
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      global_q <= 4'h0;
      srcSel_q <= 8'h00;
      rtrCfg_q <= 20'h0_0000;
      rtrMap_q <= 16'h0000;
    end
    else
    begin
      if (wrHit(ietu_pkg::A_GLOBAL))
        global_q <= hwdata[3:0];
      if (wrHit(ietu_pkg::A_SRC_SEL))
        srcSel_q <= hwdata[7:0];
      if (wrHit(ietu_pkg::A_RTR_CFG))
        rtrCfg_q <= hwdata[19:0];
      if (wrHit(ietu_pkg::A_RTR_MAP))
        rtrMap_q <= hwdata[15:0];
    end
  end

  // external request router: edge detectors on the router pins
  for (genvar i = 0; i < ietu_pkg::RTR_CH; i++)
  begin : g_rtr
    ietu_edge_detect u_edge (
      .ref_clk (ref_clk),
      .rst     (rst),
      .pinIn   (rtrPin[i]),
      .mode    (rtrCfg_q[2*i +: 2]),
      .level   (rtrLvl[i]),
      .evt     (rtrEvt[i])
    );
    ietu_gate_unit u_gate (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .evts      (rtrEvt),
      .routeMask (rtrMap_q[4*i +: 4]),
      .levels    (rtrLvl),
      .patRef    (rtrCfg_q[11:8]),
      .mode      (rtrCfg_q[12 + 2*i +: 2]),
      .req       (gateReq[i])
    );
  end

  // service request pins, active on the falling edge
  for (genvar i = 0; i < ietu_pkg::SRP_PINS; i++)
  begin : g_srv
    ietu_edge_detect u_srv (
      .ref_clk (ref_clk),
      .rst     (rst),
      .pinIn   (srvPin[i]),
      .mode    (ietu_pkg::EM_FALL),
      .level   (),
      .evt     (srvEvt[i])
    );
  end

  // trap sources
  always_comb
  begin
    trapEvt = {hwTrap, 3'b000};
    trapEvt[ietu_pkg::T_SR0]   = srvEvt[0] && global_q[ietu_pkg::G_SR0];
    trapEvt[ietu_pkg::T_SR1]   = (srvEvt[1] || srvEvt[2]) && global_q[ietu_pkg::G_SR1];
    trapEvt[ietu_pkg::T_GUARD] = accessViolation && global_q[ietu_pkg::G_GUARD];
  end

  // flags are sticky and write-one-to-clear; a new trap wins over the clear
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      trapFlags_q <= 8'h00;
    else if (wrHit(ietu_pkg::A_TRAP_FLAGS))
      trapFlags_q <= (trapFlags_q & ~hwdata[7:0]) | trapEvt;
    else
      trapFlags_q <= trapFlags_q | trapEvt;
  end

  // most urgent pending trap, taken unless the same or a more urgent one is in service
  always_comb
  begin
    trapIdx = 3'h0;
    for (int t = ietu_pkg::TRAPS - 1; t >= 0; t--)
      if (trapPend_q[t])
        trapIdx = 3'(t);
    trapPick = (|trapPend_q) && ({1'b0, trapIdx} < trapLevel_q);
  end

  // node request sources, with shared nodes and router outputs folded in
  always_comb
  begin
    nodeSrc = srcReq;
    for (int s = 0; s < ietu_pkg::SHARED_NODES; s++)
      nodeSrc[ietu_pkg::SHARED_BASE + s] = srcSel_q[s] ? altSrc[s]
                                         : srcReq[ietu_pkg::SHARED_BASE + s];
    for (int g = 0; g < ietu_pkg::RTR_CH; g++)
      nodeSrc[ietu_pkg::GATE_NODE_BASE + g] = srcReq[ietu_pkg::GATE_NODE_BASE + g] | gateReq[g];
    nodeSrc[gIdx_q] = nodeSrc[gIdx_q] | hitZero;
  end

  // arbitration: highest nonzero enabled priority wins, ties go to the lower node
  always_comb
  begin
    best    = 7'h00;
    bestPri = 4'h0;
    found   = 1'b0;
    for (int n = 0; n < ietu_pkg::NODES; n++)
      if (nodeCtrl_q[n][ietu_pkg::NC_REQ] && nodeCtrl_q[n][ietu_pkg::NC_EN]
          && nodeCtrl_q[n][ietu_pkg::NC_PRI_HI:ietu_pkg::NC_PRI_LO] > bestPri)
      begin
        best    = 7'(n);
        bestPri = nodeCtrl_q[n][ietu_pkg::NC_PRI_HI:ietu_pkg::NC_PRI_LO];
        found   = 1'b1;
      end
  end

  assign gCh     = nodeCtrl_q[gIdx_q][ietu_pkg::NC_CH_HI:ietu_pkg::NC_CH_LO];
  assign moveNow = (state_q == ST_MOVE);
  assign hitZero = moveNow && !chCtrl_q[gCh][ietu_pkg::CC_CONT] && (chCnt_q[gCh] == 8'h01);
  assign clrNode = moveNow || (state_q == ST_VECTOR && svcAck && isNode_q);

  // node control registers: software write, else acceptance clear, then hardware set wins
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int n = 0; n < ietu_pkg::NODES; n++)
        nodeCtrl_q[n] <= 10'h000;
    end
    else
    begin
      for (int n = 0; n < ietu_pkg::NODES; n++)
      begin
        if (wrHit(12'(n * 4)))
          nodeCtrl_q[n] <= hwdata[ietu_pkg::NC_W-1:0];
        else if (clrNode && gIdx_q == 7'(n))
          nodeCtrl_q[n][ietu_pkg::NC_REQ] <= 1'b0;
        if (nodeSrc[n])
          nodeCtrl_q[n][ietu_pkg::NC_REQ] <= 1'b1;
      end
    end
  end

  // transfer channels: pointers and counter, updated by software or by a move
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int c = 0; c < ietu_pkg::CHANS; c++)
      begin
        chCtrl_q[c] <= 4'h0;
        chSrc_q[c]  <= 24'h00_0000;
        chDst_q[c]  <= 24'h00_0000;
        chCnt_q[c]  <= 8'h00;
      end
    end
    else
    begin
      for (int c = 0; c < ietu_pkg::CHANS; c++)
      begin
        if (wrHit(ietu_pkg::A_CHAN_BASE + 12'(c * 16)))
          chCtrl_q[c] <= hwdata[3:0];
        if (wrHit(ietu_pkg::A_CHAN_BASE + 12'(c * 16 + 4)))
          chSrc_q[c] <= hwdata[23:0];
        if (wrHit(ietu_pkg::A_CHAN_BASE + 12'(c * 16 + 8)))
          chDst_q[c] <= hwdata[23:0];
        if (wrHit(ietu_pkg::A_CHAN_BASE + 12'(c * 16 + 12)))
          chCnt_q[c] <= hwdata[7:0];
      end
      if (moveNow)
      begin
        if (chCtrl_q[gCh][ietu_pkg::CC_INC_SRC])
          chSrc_q[gCh] <= chSrc_q[gCh] + (chCtrl_q[gCh][ietu_pkg::CC_WORD] ? 24'h2 : 24'h1);
        if (chCtrl_q[gCh][ietu_pkg::CC_INC_DST])
          chDst_q[gCh] <= chDst_q[gCh] + (chCtrl_q[gCh][ietu_pkg::CC_WORD] ? 24'h2 : 24'h1);
        if (!chCtrl_q[gCh][ietu_pkg::CC_CONT])
          chCnt_q[gCh] <= chCnt_q[gCh] - 8'h01;
      end
    end
  end

  // pending traps and the software trap request
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      trapPend_q <= 8'h00;
      swPend_q   <= 1'b0;
      swNum_q    <= 8'h00;
    end
    else
    begin
      if (state_q == ST_VECTOR && svcAck && isTrap_q)
        trapPend_q <= (trapPend_q & ~(8'h01 << vec_q[2:0])) | trapEvt;
      else
        trapPend_q <= trapPend_q | trapEvt;
      if (swTrapValid)
      begin
        swPend_q <= 1'b1;
        swNum_q  <= swTrapNum;
      end
      else if (state_q == ST_VECTOR && svcAck && !isTrap_q && !isNode_q)
        swPend_q <= 1'b0;
    end
  end

  // trap service level, released when the cpu reports the trap handler done
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      trapLevel_q <= ietu_pkg::NO_TRAP;
    else if (state_q == ST_VECTOR && svcAck && isTrap_q)
      trapLevel_q <= {1'b0, vec_q[2:0]};
    else if (trapDone)
      trapLevel_q <= ietu_pkg::NO_TRAP;
  end

  // service sequencer; a trap may take over a standard service not yet accepted
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_q  <= ST_IDLE;
      cnt_q    <= 4'h0;
      vec_q    <= 8'h00;
      isTrap_q <= 1'b0;
      isNode_q <= 1'b0;
      gIdx_q   <= 7'h00;
    end
    else
    begin
      case (state_q)
        ST_IDLE, ST_WAIT, ST_VECTOR:
        begin
          if (trapPick && !(state_q != ST_IDLE && isTrap_q))
          begin
            state_q  <= ST_WAIT;
            vec_q    <= {5'h00, trapIdx};
            isTrap_q <= 1'b1;
            isNode_q <= 1'b0;
            cnt_q    <= (global_q[ietu_pkg::G_JCACHE] ? ietu_pkg::LAT_JC : ietu_pkg::LAT_NOJC)
                        - ietu_pkg::LAT_PRE;
          end
          else if (state_q == ST_WAIT)
          begin
            if (cnt_q == 4'h0)
              state_q <= ST_VECTOR;
            else
              cnt_q <= cnt_q - 4'h1;
          end
          else if (state_q == ST_VECTOR)
          begin
            if (svcAck)
              state_q <= ST_IDLE;
          end
          else if (trapLevel_q == ietu_pkg::NO_TRAP && swPend_q)
          begin
            state_q  <= ST_WAIT;
            vec_q    <= swNum_q;
            isTrap_q <= 1'b0;
            isNode_q <= 1'b0;
            cnt_q    <= (global_q[ietu_pkg::G_JCACHE] ? ietu_pkg::LAT_JC : ietu_pkg::LAT_NOJC)
                        - ietu_pkg::LAT_PRE;
          end
          else if (trapLevel_q == ietu_pkg::NO_TRAP && found)
          begin
            gIdx_q   <= best;
            isTrap_q <= 1'b0;
            isNode_q <= 1'b1;
            if (nodeCtrl_q[best][ietu_pkg::NC_XFER]
                && (chCtrl_q[nodeCtrl_q[best][ietu_pkg::NC_CH_HI:ietu_pkg::NC_CH_LO]]
                    [ietu_pkg::CC_CONT]
                    || chCnt_q[nodeCtrl_q[best][ietu_pkg::NC_CH_HI:ietu_pkg::NC_CH_LO]] != 8'h00))
              state_q <= ST_MOVE;
            else
            begin
              state_q <= ST_WAIT;
              vec_q   <= ietu_pkg::VEC_BASE + {1'b0, best};
              cnt_q   <= (global_q[ietu_pkg::G_JCACHE] ? ietu_pkg::LAT_JC : ietu_pkg::LAT_NOJC)
                         - ietu_pkg::LAT_PRE;
            end
          end
        end
        ST_MOVE:
          state_q <= ST_IDLE;
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // cpu side outputs
  assign svcValid  = (state_q == ST_VECTOR);
  assign svcVector = vec_q;
  assign svcIsTrap = isTrap_q;
  assign xferValid = moveNow;
  assign cpuStall  = moveNow;
  assign xferWord  = chCtrl_q[gCh][ietu_pkg::CC_WORD];
  assign xferSrc   = chSrc_q[gCh];
  assign xferDst   = chDst_q[gCh];
endmodule

// *** logic/ietu_pkg.sv ***
package ietu_pkg;
  // sizes of the controller
  localparam int NODES          = 112;
  localparam int CHANS          = 8;
  localparam int TRAPS          = 8;
  localparam int RTR_CH         = 4;
  localparam int SRP_PINS       = 3;
  localparam int SHARED_BASE    = 104;
  localparam int SHARED_NODES   = 8;
  localparam int GATE_NODE_BASE = 100;

  // word offsets on the bus (low 12 address bits, upper bits must be zero)
  localparam logic [11:0] A_NODE_LAST  = 12'h01BC;
  localparam logic [11:0] A_CHAN_BASE  = 12'h0200;
  localparam logic [11:0] A_TRAP_FLAGS = 12'h0300;
  localparam logic [11:0] A_GLOBAL     = 12'h0304;
  localparam logic [11:0] A_SRC_SEL    = 12'h0308;
  localparam logic [11:0] A_RTR_CFG    = 12'h030C;
  localparam logic [11:0] A_RTR_MAP    = 12'h0310;
  localparam logic [11:0] A_STATUS     = 12'h0314;
  // channel register slot inside a 16-byte channel block
  localparam logic [1:0]  CR_CTRL = 2'h0;
  localparam logic [1:0]  CR_SRC  = 2'h1;
  localparam logic [1:0]  CR_DST  = 2'h2;
  localparam logic [1:0]  CR_CNT  = 2'h3;

  // node control fields
  localparam int NC_W      = 10;
  localparam int NC_REQ    = 0;
  localparam int NC_EN     = 1;
  localparam int NC_PRI_LO = 2;
  localparam int NC_PRI_HI = 5;
  localparam int NC_XFER   = 6;
  localparam int NC_CH_LO  = 7;
  localparam int NC_CH_HI  = 9;

  // channel control fields
  localparam int CC_WORD    = 0;
  localparam int CC_INC_SRC = 1;
  localparam int CC_INC_DST = 2;
  localparam int CC_CONT    = 3;

  // global control fields
  localparam int G_GUARD  = 0;
  localparam int G_JCACHE = 1;
  localparam int G_SR0    = 2;
  localparam int G_SR1    = 3;

  // trap numbers, lower number is more urgent
  localparam int T_SR0   = 0;
  localparam int T_SR1   = 1;
  localparam int T_GUARD = 2;
  localparam int T_HW_LO = 3;

  // response latency in cpu clocks, and the preload that yields it
  localparam logic [3:0] LAT_JC    = 4'h7;
  localparam logic [3:0] LAT_NOJC  = 4'hB;
  localparam logic [3:0] LAT_PRE   = 4'h2;
  localparam logic [7:0] VEC_BASE  = 8'h10;
  localparam logic [3:0] NO_TRAP   = 4'h8;

  // edge and gating modes
  localparam logic [1:0] EM_OFF   = 2'h0;
  localparam logic [1:0] EM_RISE  = 2'h1;
  localparam logic [1:0] EM_FALL  = 2'h2;
  localparam logic [1:0] EM_BOTH  = 2'h3;
  localparam logic [1:0] GM_PASS  = 2'h0;
  localparam logic [1:0] GM_MATCH = 2'h1;
  localparam logic [1:0] GM_MISS  = 2'h2;
  localparam logic [1:0] GM_OFF   = 2'h3;
endpackage

// *** logic/ietu_edge_detect.sv ***
`timescale 1ns/1ns
module ietu_edge_detect (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       pinIn,
  input  wire logic [1:0] mode,
  output logic            level,
  output logic            evt
);
  logic sync1_q;
  logic sync2_q;
  logic prev_q;
  logic evt_q;

  // two stages before anything looks at the pin
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q  <= 1'b0;
    end
    else
    begin
      sync1_q <= pinIn;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  // selectable edge, one-cycle event
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      evt_q <= 1'b0;
    else
      evt_q <= ((mode == ietu_pkg::EM_RISE || mode == ietu_pkg::EM_BOTH) && sync2_q && !prev_q)
            || ((mode == ietu_pkg::EM_FALL || mode == ietu_pkg::EM_BOTH) && !sync2_q && prev_q);
  end

  assign level = sync2_q;
  assign evt   = evt_q;
endmodule

// *** logic/ietu_gate_unit.sv ***
`timescale 1ns/1ns
module ietu_gate_unit (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic [3:0] evts,
  input  wire logic [3:0] routeMask,
  input  wire logic [3:0] levels,
  input  wire logic [3:0] patRef,
  input  wire logic [1:0] mode,
  output logic            req
);
  logic req_q;
  logic hit;
  logic match;

  // combine routed events, then filter on the level pattern
  assign hit   = |(evts & routeMask);
  assign match = (levels == patRef);

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      req_q <= 1'b0;
    else
    begin
      case (mode)
        ietu_pkg::GM_PASS:  req_q <= hit;
        ietu_pkg::GM_MATCH: req_q <= hit && match;
        ietu_pkg::GM_MISS:  req_q <= hit && !match;
        default:            req_q <= 1'b0;
      endcase
    end
  end

  assign req = req_q;
endmodule

// *** tb/ietu_top_properties.sv ***
`timescale 1ns/1ns
module ietu_top_properties (
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       hreadyout,
  input wire logic       hresp,
  input wire logic       svcValid,
  input wire logic [7:0] svcVector,
  input wire logic       svcIsTrap,
  input wire logic       svcAck,
  input wire logic       trapDone,
  input wire logic       xferValid,
  input wire logic       cpuStall
);
  logic trapBusy_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // trap handler running on the core, cleared by its end pulse
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      trapBusy_q <= 1'b0;
    else if (trapDone)
      trapBusy_q <= 1'b0;
    else if (svcValid && svcAck && svcIsTrap)
      trapBusy_q <= 1'b1;
  a_quiet_after_reset: assert property ($fell(rst) |-> !svcValid && !xferValid)
    else $error("service offered at reset release");
  a_bus_okay_resp: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  a_stall_tracks_move: assert property (cpuStall == xferValid)
    else $error("stall differs from move");
  a_move_one_cycle: assert property (xferValid |=> !xferValid)
    else $error("move longer than one cycle");
  a_ack_ends_offer: assert property (svcValid && svcAck |=> !svcValid)
    else $error("offer stands after ack");
  a_trap_vector_range: assert property (svcValid && svcIsTrap |-> svcVector < 8'h08)
    else $error("trap vector out of range");
  a_trap_blocks_svc: assert property (trapBusy_q |-> !(svcValid && !svcIsTrap))
    else $error("service during trap");
  a_trap_blocks_move: assert property (trapBusy_q && $past(trapBusy_q) |-> !xferValid)
    else $error("move during trap");
  c_move: cover property (xferValid);
  c_trap_taken: cover property (svcValid && svcAck && svcIsTrap);
  c_node_taken: cover property (svcValid && svcAck && !svcIsTrap);
endmodule
bind ietu_top ietu_top_properties chk (.ref_clk, .rst, .hreadyout, .hresp, .svcValid,
  .svcVector, .svcIsTrap, .svcAck, .trapDone, .xferValid, .cpuStall);

// *** tb/ietu_cpu_model.sv ***
`timescale 1ns/1ns
module ietu_cpu_model #(
  parameter int ACK_DLY  = 3,
  parameter int DONE_DLY = 30
) (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic svcValid,
  input  wire logic svcIsTrap,
  output logic      svcAck,
  output logic      trapDone
);
  int ackCnt_q;
  int doneCnt_q;
  // slow core: takes a vector late, so the offer must hold
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      svcAck    <= 1'b0;
      trapDone  <= 1'b0;
      ackCnt_q  <= 0;
      doneCnt_q <= 0;
    end
    else
    begin
      svcAck    <= svcValid && !svcAck && ackCnt_q == ACK_DLY;
      ackCnt_q  <= (svcValid && !svcAck && ackCnt_q < ACK_DLY) ? ackCnt_q + 1 : 0;
      trapDone  <= doneCnt_q == DONE_DLY;
      doneCnt_q <= (svcAck && svcIsTrap) ? 1 : (doneCnt_q % DONE_DLY == 0 ? 0 : doneCnt_q + 1);
    end
endmodule

// *** tb/ietu_top_tb.sv ***
`timescale 1ns/1ns
`define CHK(nm, e, g) checks_done++; if ((g) !== (e)) begin n_mismatch++; $display("[ERR] %s exp %h got %h", nm, e, g); end
module ietu_top_tb;
  logic         ref_clk = 1'b0, rst = 1'b1, hsel = 1'b1, hwrite = 1'b0, swTrapValid = 1'b0;
  logic         accessViolation = 1'b0, hready, hreadyout, hresp, svcValid, svcIsTrap;
  logic         svcAck, trapDone, xferValid, xferWord, cpuStall;
  logic [31:0]  haddr = '0, hwdata = '0, hrdata;
  logic [1:0]   htrans = 2'h0;
  logic [2:0]   hsize = 3'h2, srvPin = 3'h7;
  logic [111:0] srcReq = '0;
  logic [7:0]   altSrc = 8'h00, swTrapNum = 8'h00, svcVector;
  logic [3:0]   rtrPin = 4'h0;
  logic [4:0]   hwTrap = 5'h00;
  logic [23:0]  xferSrc, xferDst;
  int           n_mismatch = 0, checks_done = 0, cyc = 0, n;

  ietu_top dut (.ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .srcReq, .altSrc, .rtrPin, .srvPin, .hwTrap, .accessViolation,
    .swTrapValid, .swTrapNum, .svcValid, .svcVector, .svcIsTrap, .svcAck, .trapDone,
    .xferValid, .xferWord, .xferSrc, .xferDst, .cpuStall);
  ietu_cpu_model cpu (.ref_clk, .rst, .svcValid, .svcIsTrap, .svcAck, .trapDone);
  // single slave, so its ready is the bus ready
  assign hready = hreadyout;
  always #5 ref_clk = ~ref_clk;

  task wrap_up();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // one single transfer; read data sits in hrdata at return
  task bus(input logic [11:0] a, input logic w, input logic [31:0] d);
    haddr  <= {20'h0_0000, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge ref_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hready !== 1'b1);
  endtask
  task rc(input logic [11:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0000_0000);
    `CHK("hrdata", e, hrdata)
  endtask
  // edges counted in n; bounded so a lost service cannot hang
  task waitFor(input logic x);
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while ((x ? xferValid : svcValid) !== 1'b1 && n < 400);
    `CHK("wait", 1'b1, n < 400)
  endtask
  task svcIs(input logic [7:0] v);
    waitFor(1'b0);
    `CHK("svcVector", v, svcVector)
    `CHK("svcIsTrap", v < 8'h08, svcIsTrap)
    do @(posedge ref_clk); while (svcValid !== 1'b0);
  endtask
  task pulse(input logic [111:0] m);
    srcReq <= m;
    @(posedge ref_clk);
    srcReq <= '0;
  endtask
  // hang guard
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      wrap_up();
    end
  end

  initial
  begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    rc(ietu_pkg::A_STATUS, 32'h0000_1000);
    rc(12'hFFC, 32'h0000_0000);
    for (int j = 0; j < 2; j++)
    begin
      bus(ietu_pkg::A_GLOBAL, 1'b1, j ? 32'h0000_0000 : 32'h0000_0002);
      bus(12'h014, 1'b1, 32'h0000_000F);
      svcIs(8'h15);
      `CHK("latency", j ? ietu_pkg::LAT_NOJC + 1 : ietu_pkg::LAT_JC + 1, n)
      rc(12'h014, 32'h0000_000E);
    end
    bus(12'h01C, 1'b1, 32'h0000_000A);
    bus(12'h024, 1'b1, 32'h0000_0016);
    pulse(112'h0280);
    svcIs(8'h19);
    svcIs(8'h17);
    bus(12'h230, 1'b1, 32'h0000_0007);
    bus(12'h234, 1'b1, 32'h0000_0100);
    bus(12'h238, 1'b1, 32'h0000_0200);
    bus(12'h23C, 1'b1, 32'h0000_0002);
    bus(12'h050, 1'b1, 32'h0000_01C6);
    for (int k = 0; k < 2; k++)
    begin
      pulse(112'h10_0000);
      waitFor(1'b1);
      `CHK("xferSrc", 32'h0000_0100 + 2 * k, xferSrc)
      `CHK("xferDst", 32'h0000_0200 + 2 * k, xferDst)
      `CHK("xferWord", 1'b1, xferWord)
    end
    svcIs(8'h24);
    rc(12'h23C, 32'h0000_0000);
    bus(12'h270, 1'b1, 32'h0000_0008);
    bus(12'h27C, 1'b1, 32'h0000_0001);
    bus(12'h054, 1'b1, 32'h0000_03C6);
    pulse(112'h20_0000);
    waitFor(1'b1);
    `CHK("xferWord", 1'b0, xferWord)
    rc(12'h27C, 32'h0000_0001);
    bus(ietu_pkg::A_RTR_MAP, 1'b1, 32'h0000_0001);
    bus(12'h190, 1'b1, 32'h0000_0006);
    for (int i = 1; i < 4; i++)
    begin
      bus(ietu_pkg::A_RTR_CFG, 1'b1, 32'(i));
      rtrPin[0] <= ~rtrPin[0];
      svcIs(8'h74);
    end
    // gate 0 filtered on pin level pattern 0001: match blocks a fall, passes a rise; miss passes
    for (int i = 0; i < 3; i++)
    begin
      bus(ietu_pkg::A_RTR_CFG, 1'b1, i == 2 ? 32'h0000_2103 : 32'h0000_1103);
      rtrPin[0] <= ~rtrPin[0];
      repeat (6) @(posedge ref_clk);
      if (i == 0)
        rc(12'h190, 32'h0000_0006);
      else
        svcIs(8'h74);
    end
    bus(ietu_pkg::A_SRC_SEL, 1'b1, 32'h0000_0001);
    bus(12'h1A0, 1'b1, 32'h0000_0006);
    altSrc <= 8'h01;
    @(posedge ref_clk);
    altSrc <= 8'h00;
    svcIs(8'h78);
    swTrapNum <= 8'h40;
    swTrapValid <= 1'b1;
    @(posedge ref_clk);
    swTrapValid <= 1'b0;
    svcIs(8'h40);
    hwTrap <= 5'h01;
    @(posedge ref_clk);
    hwTrap <= 5'h00;
    svcIs(8'h03);
    rc(ietu_pkg::A_TRAP_FLAGS, 32'h0000_0008);
    bus(ietu_pkg::A_TRAP_FLAGS, 1'b1, 32'h0000_0008);
    bus(12'h014, 1'b1, 32'h0000_000F);
    rc(ietu_pkg::A_TRAP_FLAGS, 32'h0000_0000);
    svcIs(8'h15);
    `CHK("held", 1'b1, n > ietu_pkg::LAT_NOJC + 1)
    bus(ietu_pkg::A_GLOBAL, 1'b1, 32'h0000_0005);
    accessViolation <= 1'b1;
    @(posedge ref_clk);
    accessViolation <= 1'b0;
    svcIs(8'h02);
    srvPin[0] <= 1'b0;
    svcIs(8'h00);
    rc(ietu_pkg::A_TRAP_FLAGS, 32'h0000_0005);
    bus(ietu_pkg::A_GLOBAL, 1'b1, 32'h0000_0008);
    srvPin[2] <= 1'b0;
    repeat (6) @(posedge ref_clk);
    rc(ietu_pkg::A_TRAP_FLAGS, 32'h0000_0007);
    wrap_up();
  end
endmodule
